// [hdl/wcm_regs.svh]
// register offsets, field positions and timing figures of the watchdog block
`ifndef WCM_REGS_SVH
`define WCM_REGS_SVH
`define WCM_CLEAR_ADDR      16'h1ff0
`define WCM_CTRL_ADDR       16'h001d
`define WCM_STAT_ADDR       16'h001e
`define WCM_PCLR_ADDR       16'h001f
`define WCM_CLEAR_BIT       0
`define WCM_MOR_FIXEN_BIT   0
`define WCM_CTRL_CME_BIT    0
`define WCM_CTRL_PWD_BIT    1
`define WCM_STAT_FIX_BIT    0
`define WCM_STAT_MON_BIT    1
`define WCM_STAT_PROG_BIT   2
`define WCM_STAT_PIN_BIT    3
`define WCM_CTRL_RESET      8'h00
`define WCM_STAT_RESET      8'h00
`define WCM_READ_ZERO       8'h00
`define WCM_CLK_PERIOD_NS   5
`define WCM_BUS_PERIOD_NS   476
`define WCM_HOLD_BUS_CYCLES 4
`define WCM_MON_TIMEOUT_NS  20000
`define WCM_FIX_TIMEOUT_BUS 65536
`define WCM_PRG_TIMEOUT_BUS 16384
`define WCM_HOLD_CLKS \
  ((`WCM_HOLD_BUS_CYCLES * `WCM_BUS_PERIOD_NS + `WCM_CLK_PERIOD_NS - 1) \
   / `WCM_CLK_PERIOD_NS)
`define WCM_MON_CLKS (`WCM_MON_TIMEOUT_NS / `WCM_CLK_PERIOD_NS)
`endif

// [hdl/wcm_pkg.sv]
// types shared by the watchdog and clock monitor block
package wcm_pkg;
  typedef logic [7:0]  wcm_byte_t;
  typedef logic [15:0] wcm_addr_t;
  typedef enum logic [1:0] {
    WCM_PIN_IDLE,
    WCM_PIN_DRIVE,
    WCM_PIN_SETTLE
  } wcm_pin_state_t;
endpackage : wcm_pkg

// [hdl/wcm_tick_if.sv]
// link between the reset controller and one watchdog timer
`timescale 1ns/10ps
`default_nettype none
interface wcm_tick_if;
  logic tick;
  logic clear;
  logic enable;
  logic expire;
  modport ctrl  (output tick, output clear, output enable, input expire);
  modport timer (input tick, input clear, input enable, output expire);
endinterface : wcm_tick_if
`default_nettype wire

// [hdl/wcm_cop_timer.sv]
// watchdog timer counting bus clock ticks up to a fixed timeout
`timescale 1ns/10ps
`default_nettype none
`include "wcm_regs.svh"
module wcm_cop_timer #(
  parameter int unsigned TIMEOUT = `WCM_FIX_TIMEOUT_BUS
) (
  input  wire logic   clk_in,
  input  wire logic   reset_in,
  wcm_tick_if.timer   t
);
  localparam int unsigned W = $clog2(TIMEOUT + 1);
  localparam logic [W-1:0] LAST = W'(TIMEOUT - 1);
  logic [W-1:0] cnt_reg;
  logic         expire_reg;

  // wait mode is not an input here: the count never pauses for it
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      cnt_reg <= '0;
    end else if (t.clear || !t.enable) begin
      cnt_reg <= '0;
    end else if (t.tick) begin
      cnt_reg <= (cnt_reg == LAST) ? '0 : cnt_reg + W'(1);
    end
  end

  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      expire_reg <= 1'b0;
    end else begin
      expire_reg <= t.enable && !t.clear && t.tick && (cnt_reg == LAST);
    end
  end
  assign t.expire = expire_reg;

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (reset_in);
  clear_restarts_a: assert property (t.clear |=> cnt_reg == '0)
    else $error("timer not restarted by clear");
  ticks_count_a: assert property (
    t.enable && !t.clear && t.tick && cnt_reg != LAST
    |=> cnt_reg == $past(cnt_reg) + W'(1))
    else $error("timer failed to advance on tick");
  expire_at_end_a: assert property (
    expire_reg |-> $past(cnt_reg) == LAST && $past(t.enable))
    else $error("timer expired early");
endmodule : wcm_cop_timer
`default_nettype wire

// [hdl/wcm_clk_monitor.sv]
// clock monitor: flags a bus clock that has gone quiet for too long
`timescale 1ns/10ps
`default_nettype none
`include "wcm_regs.svh"
module wcm_clk_monitor #(
  parameter int unsigned TIMEOUT = `WCM_MON_CLKS
) (
  input  wire logic clk_in,
  input  wire logic reset_in,
  input  wire logic enable_in,
  input  wire logic bus_edge_in,
  input  wire logic halt_in,
  output var  logic fault_out
);
  localparam int unsigned W = $clog2(TIMEOUT + 1);
  localparam logic [W-1:0] LAST = W'(TIMEOUT - 1);
  logic [W-1:0] gap_reg;
  logic         fault_reg;
  logic         quiet;

  // a halted core stops the bus clock, so halt counts as silence
  assign quiet = halt_in || !bus_edge_in;

  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      gap_reg <= '0;
    end else if (!enable_in || !quiet || gap_reg == LAST) begin
      gap_reg <= '0;
    end else begin
      gap_reg <= gap_reg + W'(1);
    end
  end

  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      fault_reg <= 1'b0;
    end else begin
      fault_reg <= enable_in && quiet && gap_reg == LAST;
    end
  end
  assign fault_out = fault_reg;

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (reset_in);
  silence_faults_a: assert property (
    enable_in && quiet && gap_reg == LAST |=> fault_reg)
    else $error("silent bus clock not flagged");
  halt_counts_a: assert property (
    enable_in && halt_in && gap_reg != LAST
    |=> gap_reg == $past(gap_reg) + W'(1))
    else $error("halt not treated as missing clock");
  off_no_fault_a: assert property (!enable_in |=> !fault_reg)
    else $error("fault while monitor disabled");
endmodule : wcm_clk_monitor
`default_nettype wire

// [hdl/wcm_top.sv]
// reset source logic: fixed and programmable watchdogs, clock monitor, pin
`timescale 1ns/10ps
`default_nettype none
`include "wcm_regs.svh"
module wcm_top #(
  parameter int unsigned FIX_TIMEOUT = `WCM_FIX_TIMEOUT_BUS,
  parameter int unsigned PRG_TIMEOUT = `WCM_PRG_TIMEOUT_BUS,
  parameter int unsigned MON_CLKS    = `WCM_MON_CLKS,
  parameter int unsigned HOLD_CLKS   = `WCM_HOLD_CLKS
) (
  input  wire logic              clk_in,
  input  wire logic              reset_in,
  input  wire wcm_pkg::wcm_addr_t addr_in,
  input  wire wcm_pkg::wcm_byte_t wr_data_in,
  input  wire logic              wr_in,
  input  wire logic              rd_in,
  output var  wcm_pkg::wcm_byte_t rd_data_out,
  input  wire logic              bus_clk_in,
  input  wire logic              halt_in,
  input  wire logic              wait_in,
  input  wire logic              bootloader_mode_in,
  input  wire wcm_pkg::wcm_byte_t mask_option_reg_one_in,
  input  wire logic              reset_pin_in,
  output var  logic              reset_pin_out,
  output var  logic              reset_pin_oe_n_out,
  output var  logic              system_reset_out
);
  localparam int unsigned HW = $clog2(HOLD_CLKS + 1);
  localparam logic [HW-1:0] HOLD_LAST = HW'(HOLD_CLKS - 1);

  function automatic logic hit(input wcm_pkg::wcm_addr_t a,
                               input wcm_pkg::wcm_addr_t target);
    hit = (a == target);
  endfunction : hit

  ////////////////////////////////////////////////////////////////////////////
  // bus clock edge detection and register decode
  logic                    bus_clk_prev_reg;
  logic                    bus_edge;
  wcm_pkg::wcm_byte_t      ctrl_reg;
  wcm_pkg::wcm_byte_t      stat_reg;
  wcm_pkg::wcm_byte_t      stat_next;
  wcm_pkg::wcm_byte_t      rd_next;
  logic                    fix_clear_wr;
  logic                    prg_clear_wr;
  logic                    fix_enable_raw;
  logic                    clock_monitor_enable;
  logic                    mon_fault;
  logic                    drive_req;
  wcm_pkg::wcm_pin_state_t pin_state_reg;
  logic [HW-1:0]           hold_reg;
  logic                    pin_low_reg;

  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      bus_clk_prev_reg <= 1'b0;
    end else begin
      bus_clk_prev_reg <= bus_clk_in;
    end
  end
  assign bus_edge = bus_clk_in && !bus_clk_prev_reg;

  assign fix_clear_wr = wr_in && hit(addr_in, `WCM_CLEAR_ADDR)
                        && !wr_data_in[`WCM_CLEAR_BIT];
  assign prg_clear_wr = wr_in && hit(addr_in, `WCM_PCLR_ADDR);
  assign clock_monitor_enable = ctrl_reg[`WCM_CTRL_CME_BIT];
  // the option bit only counts outside bootloader mode
  assign fix_enable_raw = mask_option_reg_one_in[`WCM_MOR_FIXEN_BIT]
                          && !bootloader_mode_in;

  ////////////////////////////////////////////////////////////////////////////
  // watchdog timers; wait_in deliberately feeds neither of them
  wcm_tick_if fix_if ();
  wcm_tick_if prg_if ();

  assign fix_if.tick   = bus_edge;
  assign fix_if.clear  = fix_clear_wr || pin_low_reg;
  assign fix_if.enable = fix_enable_raw;
  assign prg_if.tick   = bus_edge;
  assign prg_if.clear  = prg_clear_wr || pin_low_reg;
  assign prg_if.enable = ctrl_reg[`WCM_CTRL_PWD_BIT];

  wcm_cop_timer #(.TIMEOUT(FIX_TIMEOUT)) u_fix (
    .clk_in   (clk_in),
    .reset_in (reset_in),
    .t        (fix_if.timer)
  );

  wcm_cop_timer #(.TIMEOUT(PRG_TIMEOUT)) u_prg (
    .clk_in   (clk_in),
    .reset_in (reset_in),
    .t        (prg_if.timer)
  );

  // below a 50 kHz bus clock this may fire in normal running
  wcm_clk_monitor #(.TIMEOUT(MON_CLKS)) u_mon (
    .clk_in      (clk_in),
    .reset_in    (reset_in),
    .enable_in   (clock_monitor_enable),
    .bus_edge_in (bus_edge),
    .halt_in     (halt_in),
    .fault_out   (mon_fault)
  );

  assign drive_req = mon_fault || fix_if.expire
                     || prg_if.expire;

  ////////////////////////////////////////////////////////////////////////////
  // control register; a system reset returns it to its reset value
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      ctrl_reg <= `WCM_CTRL_RESET;
    end else if (system_reset_out) begin
      ctrl_reg <= `WCM_CTRL_RESET;
    end else if (wr_in && hit(addr_in, `WCM_CTRL_ADDR)) begin
      ctrl_reg <= wr_data_in;
    end
  end

  // reset cause flags survive a system reset; set wins over write-one clear
  always_comb begin
    stat_next = stat_reg;
    if (wr_in && hit(addr_in, `WCM_STAT_ADDR)) begin
      stat_next = stat_reg & ~wr_data_in;
    end
    if (fix_if.expire) begin
      stat_next[`WCM_STAT_FIX_BIT] = 1'b1;
    end
    if (mon_fault) begin
      stat_next[`WCM_STAT_MON_BIT] = 1'b1;
    end
    if (prg_if.expire) begin
      stat_next[`WCM_STAT_PROG_BIT] = 1'b1;
    end
    if (pin_low_reg && pin_state_reg == wcm_pkg::WCM_PIN_IDLE) begin
      stat_next[`WCM_STAT_PIN_BIT] = 1'b1;
    end
  end

  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      stat_reg <= `WCM_STAT_RESET;
    end else begin
      stat_reg <= stat_next;
    end
  end

  always_comb begin
    rd_next = `WCM_READ_ZERO;
    if (hit(addr_in, `WCM_CLEAR_ADDR)) begin
      rd_next = mask_option_reg_one_in;
    end else if (hit(addr_in, `WCM_CTRL_ADDR)) begin
      rd_next = ctrl_reg;
    end else if (hit(addr_in, `WCM_STAT_ADDR)) begin
      rd_next = stat_reg;
    end
  end

  // read data stand only in the cycle after the strobe
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      rd_data_out <= `WCM_READ_ZERO;
    end else if (rd_in) begin
      rd_data_out <= rd_next;
    end else begin
      rd_data_out <= `WCM_READ_ZERO;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // reset pin: drive low for four bus periods, then wait for the line high
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      pin_low_reg <= 1'b0;
    end else begin
      pin_low_reg <= !reset_pin_in;
    end
  end

  // hold timed on clk_in, since the bus clock may be the thing that died
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      pin_state_reg <= wcm_pkg::WCM_PIN_IDLE;
      hold_reg      <= '0;
    end else begin
      case (pin_state_reg)
        wcm_pkg::WCM_PIN_IDLE: begin
          if (drive_req) begin
            pin_state_reg <= wcm_pkg::WCM_PIN_DRIVE;
            hold_reg      <= HOLD_LAST;
          end
        end
        wcm_pkg::WCM_PIN_DRIVE: begin
          if (hold_reg == '0) begin
            pin_state_reg <= wcm_pkg::WCM_PIN_SETTLE;
          end else begin
            hold_reg <= hold_reg - HW'(1);
          end
        end
        wcm_pkg::WCM_PIN_SETTLE: begin
          // an outside driver may keep the line low for a long time
          if (!pin_low_reg) begin
            pin_state_reg <= wcm_pkg::WCM_PIN_IDLE;
          end
        end
        default: begin
          pin_state_reg <= wcm_pkg::WCM_PIN_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      reset_pin_oe_n_out <= 1'b1;
    end else begin
      reset_pin_oe_n_out <= !(pin_state_reg == wcm_pkg::WCM_PIN_IDLE
                              ? drive_req
                              : pin_state_reg == wcm_pkg::WCM_PIN_DRIVE
                                && hold_reg != '0);
    end
  end
  assign reset_pin_out = 1'b0;

  // the core stays in reset while the line is low, from either side
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      system_reset_out <= 1'b1;
    end else begin
      system_reset_out <= pin_state_reg != wcm_pkg::WCM_PIN_IDLE
                          || drive_req || !reset_pin_in;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (reset_in);
  clear_read_a: assert property (
    rd_in && hit(addr_in, `WCM_CLEAR_ADDR)
    |=> rd_data_out == $past(mask_option_reg_one_in))
    else $error("clear address did not read mask option");
  rd_idle_zero_a: assert property (
    !rd_in |=> rd_data_out == `WCM_READ_ZERO)
    else $error("read data stood beyond one cycle");
  boot_disable_a: assert property (
    bootloader_mode_in |-> !fix_if.enable)
    else $error("fixed watchdog enabled in bootloader mode");
  boot_no_expire_a: assert property (
    bootloader_mode_in && $past(bootloader_mode_in) |-> !fix_if.expire)
    else $error("fixed watchdog expired in bootloader mode");
  wait_counts_a: assert property (
    wait_in && fix_enable_raw |-> fix_if.enable)
    else $error("wait mode stopped the fixed watchdog");
  fault_drives_a: assert property (
    mon_fault && pin_state_reg == wcm_pkg::WCM_PIN_IDLE
    |=> !reset_pin_oe_n_out && hold_reg == HOLD_LAST)
    else $error("clock fault did not drive reset pin");
  hold_length_a: assert property (
    $fell(reset_pin_oe_n_out) |-> !reset_pin_oe_n_out [*8])
    else $error("reset pin released too early");
  drive_resets_a: assert property (
    !reset_pin_oe_n_out |-> system_reset_out)
    else $error("reset pin driven without system reset");
  ctrl_cleared_a: assert property (
    system_reset_out |=> ctrl_reg == `WCM_CTRL_RESET)
    else $error("control register kept through reset");
  prg_flag_a: assert property (
    prg_if.expire |=> stat_reg[`WCM_STAT_PROG_BIT])
    else $error("programmable cause flag not set");
  expire_resets_a: assert property (
    fix_if.expire |=> system_reset_out)
    else $error("fixed watchdog timeout gave no reset");
  fix_set_wins_a: assert property (
    fix_if.expire && wr_in && hit(addr_in, `WCM_STAT_ADDR)
    |=> stat_reg[`WCM_STAT_FIX_BIT])
    else $error("flag clear beat a fixed timeout");
  pin_holds_a: assert property (
    !reset_pin_in |=> system_reset_out)
    else $error("low reset pin did not hold system");
  settle_holds_a: assert property (
    pin_state_reg == wcm_pkg::WCM_PIN_SETTLE && pin_low_reg
    |=> pin_state_reg == wcm_pkg::WCM_PIN_SETTLE)
    else $error("drive ended while line still low");
  mon_flag_a: assert property (
    mon_fault |=> stat_reg[`WCM_STAT_MON_BIT])
    else $error("monitor cause flag not set");

  mon_reset_c: cover property (mon_fault ##1 !reset_pin_oe_n_out);
  fix_reset_c: cover property (fix_if.expire ##1 system_reset_out);
  prg_reset_c: cover property (prg_if.expire ##1 system_reset_out);
  halt_fault_c: cover property (halt_in && clock_monitor_enable ##[1:10] mon_fault);
  clear_write_c: cover property (fix_clear_wr && fix_enable_raw);
endmodule : wcm_top
`default_nettype wire

// [tb/wcm_pin_partner.sv]
// model of the external system logic that shares the reset line
`timescale 1ns/10ps
`default_nettype none
module wcm_pin_partner (
  input  wire logic dev_drive_in,
  input  wire logic dev_oe_n_in,
  input  wire logic hold_low_in,
  output var  logic line_out
);
  // the line has a pull-up, so a released line reads high
  always_comb begin
    line_out = 1'b1;
    if (!dev_oe_n_in && !dev_drive_in) line_out = 1'b0;
    if (hold_low_in) line_out = 1'b0;
  end
endmodule : wcm_pin_partner
`default_nettype wire

// [tb/wcm_top_tb.sv]
// self-checking testbench of the watchdog and clock monitor block
`timescale 1ns/10ps
`default_nettype none
`include "wcm_regs.svh"
module wcm_top_tb;
  localparam int MON  = 20;
  // four bus periods of the four-cycle bench bus clock
  localparam int HOLD = `WCM_HOLD_BUS_CYCLES * 4;
  logic               clk_in = 1'b0;
  logic               reset_in = 1'b1;
  wcm_pkg::wcm_addr_t addr_in;
  wcm_pkg::wcm_byte_t wr_data_in, rd_data_out, mask_option_reg_one_in;
  logic               wr_in, rd_in, bus_clk_in, halt_in, wait_in;
  logic               bootloader_mode_in, reset_pin_in, reset_pin_out;
  logic               reset_pin_oe_n_out, system_reset_out;
  logic               hold_low, bus_run;
  logic [1:0]         bdiv;
  int                 mismatches = 0;
  int                 samples_checked = 0;
  ////////////////////////////////////////////////////////////////////////////
  wcm_top #(.FIX_TIMEOUT(16), .PRG_TIMEOUT(16), .MON_CLKS(MON),
            .HOLD_CLKS(HOLD)) uut (
    .clk_in(clk_in), .reset_in(reset_in), .addr_in(addr_in),
    .wr_data_in(wr_data_in), .wr_in(wr_in), .rd_in(rd_in),
    .rd_data_out(rd_data_out), .bus_clk_in(bus_clk_in),
    .halt_in(halt_in), .wait_in(wait_in),
    .bootloader_mode_in(bootloader_mode_in),
    .mask_option_reg_one_in(mask_option_reg_one_in),
    .reset_pin_in(reset_pin_in), .reset_pin_out(reset_pin_out),
    .reset_pin_oe_n_out(reset_pin_oe_n_out),
    .system_reset_out(system_reset_out));
  wcm_pin_partner partner (.dev_drive_in(reset_pin_out),
    .dev_oe_n_in(reset_pin_oe_n_out), .hold_low_in(hold_low),
    .line_out(reset_pin_in));
  ////////////////////////////////////////////////////////////////////////////
  always #2.5 clk_in = ~clk_in;
  // bus clock of four clk_in cycles, well inside the monitor timeout
  always @(posedge clk_in) begin
    if (bus_run) begin
      bdiv <= bdiv + 2'h1;
      bus_clk_in <= bdiv[1];
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string what, input wcm_pkg::wcm_byte_t seen, exp);
    samples_checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic wr(input wcm_pkg::wcm_addr_t a, input wcm_pkg::wcm_byte_t d);
    @(posedge clk_in);
    addr_in <= a;
    wr_data_in <= d;
    wr_in <= 1'b1;
    @(posedge clk_in);
    wr_in <= 1'b0;
  endtask : wr
  task automatic rd(input wcm_pkg::wcm_addr_t a,
                    output wcm_pkg::wcm_byte_t d);
    @(posedge clk_in);
    addr_in <= a;
    rd_in <= 1'b1;
    @(posedge clk_in);
    rd_in <= 1'b0;
    #1 d = rd_data_out;
  endtask : rd
  task automatic tick;
    @(posedge clk_in);
    #1;
  endtask : tick
  // waits for a device drive of the line, then times it and its release
  task automatic expect_reset(input int lo, hi, input string what);
    int n;
    int k;
    n = 0;
    k = 0;
    #1;
    while (reset_pin_oe_n_out !== 1'b0 && n < hi) begin
      tick();
      n++;
    end
    chk({what, " delay"}, 8'(n >= lo && n <= hi), 8'h01);
    chk("reset with drive", 8'(system_reset_out), 8'h01);
    while (reset_pin_oe_n_out === 1'b0 && k < 1000) begin
      tick();
      k++;
    end
    chk("drive length", 8'(k), 8'(HOLD));
    @(posedge clk_in);
    mask_option_reg_one_in <= 8'h00;
    k = 0;
    while (system_reset_out !== 1'b0 && k < 10) begin
      tick();
      k++;
    end
    chk("reset release", 8'(system_reset_out), 8'h00);
  endtask : expect_reset
  // clears through address a every 40 cycles; no drive may appear
  task automatic service(input wcm_pkg::wcm_addr_t a,
                         input wcm_pkg::wcm_byte_t d, input int rounds);
    int drv;
    drv = 0;
    repeat (rounds) begin
      wr(a, d);
      repeat (38) begin
        tick();
        if (reset_pin_oe_n_out !== 1'b1) drv++;
      end
    end
    chk("quiet drives", 8'(drv), 8'h00);
  endtask : service
  task automatic status_bit(input int b);
    wcm_pkg::wcm_byte_t d;
    rd(`WCM_STAT_ADDR, d);
    chk("status source", d & (8'h01 << b), 8'h01 << b);
    wr(`WCM_STAT_ADDR, 8'hff);
  endtask : status_bit
  ////////////////////////////////////////////////////////////////////////////
  task automatic test_regs;
    wcm_pkg::wcm_byte_t d;
    chk("reset idle", 8'(system_reset_out), 8'h00);
    rd(`WCM_CTRL_ADDR, d);
    chk("ctrl reset", d, `WCM_CTRL_RESET);
    rd(`WCM_STAT_ADDR, d);
    chk("status reset", d, `WCM_STAT_RESET);
    rd(16'h0055, d);
    chk("unmapped read", d, 8'h00);
    for (int i = 0; i < 2; i++) begin
      @(posedge clk_in);
      mask_option_reg_one_in <= (i != 0) ? 8'ha4 : 8'h5a;
      rd(`WCM_CLEAR_ADDR, d);
      chk("clear addr read", d, (i != 0) ? 8'ha4 : 8'h5a);
    end
    wr(`WCM_CTRL_ADDR, 8'h03);
    rd(`WCM_CTRL_ADDR, d);
    chk("ctrl readback", d & 8'h03, 8'h03);
    wr(`WCM_CTRL_ADDR, 8'h00);
    mask_option_reg_one_in <= 8'h00;
    $display("test regs done");
  endtask : test_regs
  task automatic test_fixed;
    @(posedge clk_in);
    mask_option_reg_one_in <= 8'h01;
    wait_in <= 1'b1;
    service(`WCM_CLEAR_ADDR, 8'hfe, 4);
    wr(`WCM_CLEAR_ADDR, 8'h01);
    expect_reset(0, 40, "fixed");
    status_bit(`WCM_STAT_FIX_BIT);
    wait_in <= 1'b0;
    $display("test fixed done");
  endtask : test_fixed
  task automatic test_boot;
    @(posedge clk_in);
    bootloader_mode_in <= 1'b1;
    mask_option_reg_one_in <= 8'h01;
    service(16'h0055, 8'h00, 5);
    mask_option_reg_one_in <= 8'h00;
    bootloader_mode_in <= 1'b0;
    $display("test boot done");
  endtask : test_boot
  task automatic test_monitor;
    wr(`WCM_CTRL_ADDR, 8'h01);
    service(16'h0055, 8'h00, 3);
    @(posedge clk_in);
    bus_run <= 1'b0;
    expect_reset(MON - 5, MON + 5, "monitor");
    bus_run <= 1'b1;
    status_bit(`WCM_STAT_MON_BIT);
    $display("test monitor done");
  endtask : test_monitor
  task automatic test_halt;
    wcm_pkg::wcm_byte_t d;
    wr(`WCM_CTRL_ADDR, 8'h01);
    @(posedge clk_in);
    halt_in <= 1'b1;
    expect_reset(MON - 5, MON + 5, "halt");
    halt_in <= 1'b0;
    rd(`WCM_CTRL_ADDR, d);
    chk("ctrl after reset", d, 8'h00);
    status_bit(`WCM_STAT_MON_BIT);
    $display("test halt done");
  endtask : test_halt
  task automatic test_prog;
    wr(`WCM_CTRL_ADDR, 8'h02);
    wait_in <= 1'b1;
    service(`WCM_PCLR_ADDR, 8'h00, 4);
    expect_reset(0, 80, "prog");
    status_bit(`WCM_STAT_PROG_BIT);
    wait_in <= 1'b0;
    $display("test prog done");
  endtask : test_prog
  task automatic test_retention;
    wcm_pkg::wcm_byte_t d;
    int bad;
    bad = 0;
    @(posedge clk_in);
    mask_option_reg_one_in <= 8'h01;
    hold_low <= 1'b1;
    repeat (4) tick();
    // a held line keeps the watchdogs cleared, so no drive of our own
    repeat (200) begin
      tick();
      if (system_reset_out !== 1'b1 || reset_pin_oe_n_out !== 1'b1) bad++;
    end
    chk("held line reset", 8'(bad), 8'h00);
    @(posedge clk_in);
    hold_low <= 1'b0;
    mask_option_reg_one_in <= 8'h00;
    repeat (5) tick();
    chk("line release", 8'(system_reset_out), 8'h00);
    status_bit(`WCM_STAT_PIN_BIT);
    rd(`WCM_STAT_ADDR, d);
    chk("status cleared", d, 8'h00);
    $display("test retention done");
  endtask : test_retention
  ////////////////////////////////////////////////////////////////////////////
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : print_verdict
  initial begin
    {addr_in, wr_data_in, wr_in, rd_in, halt_in, wait_in} = '0;
    {bootloader_mode_in, mask_option_reg_one_in, hold_low, bdiv} = '0;
    bus_clk_in = 1'b0;
    bus_run = 1'b1;
    repeat (20) @(posedge clk_in);
    reset_in <= 1'b0;
    tick();
    test_regs();
    test_fixed();
    test_boot();
    test_monitor();
    test_halt();
    test_prog();
    test_retention();
    print_verdict();
  end
  // all tests take about eleven hundred cycles; this is over thirty times that
  initial begin
    #200000;
    mismatches++;
    print_verdict();
  end
endmodule : wcm_top_tb
`default_nettype wire
